// *** hdl/tkc_pkg.sv ***
/*
  shared constants, state type and crc step for the touch-key command block.
  assumes one 50 MHz system clock; every time figure below derives cycles from it.
*/
package tkc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // clock and time figures
  localparam int CLK_HZ      = 50_000_000;
  localparam int MS_CYCLES   = CLK_HZ / 1000;  // one millisecond tick
  localparam int TIMEOUT_MS  = 100;            // inter-byte and repeat window
  localparam int SYNC_MS     = 100;            // mains sync pulse window
  localparam int RESP_MS     = 1;              // longest start of a normal answer
  localparam int EECRC_MS    = 20;             // longest eeprom crc computation
  localparam int RESP_CYCLES = RESP_MS * MS_CYCLES;

  ////////////////////////////////////////////////////////////////////////////////
  // key matrix
  localparam int NUM_KEYS  = 48;
  localparam int KEY_BYTES = 6;
  localparam int SETUPS_BYTES_DEF = 256;       // plain default, not a device figure

  ////////////////////////////////////////////////////////////////////////////////
  // command and answer bytes
  localparam logic [7:0] CMD_RESET  = 8'h04;
  localparam logic [7:0] CMD_STATUS = 8'h05;
  localparam logic [7:0] CMD_FIRST  = 8'h06;
  localparam logic [7:0] CMD_DETECT = 8'h07;
  localparam logic [7:0] CMD_SIGNAL = 8'h08;
  localparam logic [7:0] CMD_REF    = 8'h09;
  localparam logic [7:0] CMD_DELTA  = 8'h0a;
  localparam logic [7:0] CMD_ERRORS = 8'h0b;
  localparam logic [7:0] CMD_FAULT_ANALYSIS_CHECK   = 8'h0c;
  localparam logic [7:0] CMD_DUMP   = 8'h0d;
  localparam logic [7:0] CMD_EECRC  = 8'h0e;
  localparam logic [7:0] CMD_LAST   = 8'h0f;
  localparam logic [7:0] RSP_RESET  = 8'hfb;
  localparam logic [5:0] NO_KEY     = 6'h3f;
  localparam logic [7:0] DELTA_MAX  = 8'hff;
  localparam logic [7:0] FAULT_ANALYSIS_CHECK_ALL   = 8'hff;

  ////////////////////////////////////////////////////////////////////////////////
  // general status bit positions
  localparam int ST_COMMS  = 6;
  localparam int ST_FAULT_ANALYSIS_CHECK   = 5;
  localparam int ST_EEPROM = 4;
  localparam int ST_SYNC   = 3;
  localparam int ST_CALF   = 2;
  localparam int ST_INCAL  = 1;
  localparam int ST_DETECT = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // single-byte answer crc
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_FETCH  = 3'b001,
    S_SEND   = 3'b010,
    S_WAITEE = 3'b011
  } tkc_state_t;

  // msb-first crc-8 over one byte
  function automatic logic [7:0] crc8Step(input logic [7:0] crc, input logic [7:0] d);
    logic [7:0] c;
    c = crc ^ d;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

endpackage

// *** hdl/tkc_crc_if.sv ***
/*
  carrier between the command block and its crc engine.
  assumes both ends run on the same clock.
*/
interface tkc_crc_if;
  logic       seed;  // restart crc folding in data
  logic       feed;  // fold data into running crc
  logic [7:0] data;
  logic [7:0] crc;
  modport engine (input seed, input feed, input data, output crc);
  modport user   (output seed, output feed, output data, input crc);
endinterface

// *** hdl/tkc_crc8.sv ***
/*
  running crc-8 engine for answer bytes.
  assumes seed and feed never rise together and a reset already synchronised.
*/
module tkc_crc8 (
  input wire logic   clock,
  input wire logic   rstSync_n,
  tkc_crc_if.engine  crcIf
);
  import tkc_pkg::*;

  logic [7:0] crc_r;

  // seed folds the command byte into a fresh crc so each answer is bound to its command
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      crc_r <= CRC_INIT;
    end else if (crcIf.seed) begin
      crc_r <= crc8Step(CRC_INIT, crcIf.data);
    end else if (crcIf.feed) begin
      crc_r <= crc8Step(crc_r, crcIf.data);
    end
  end

  assign crcIf.crc = crc_r;

endmodule

// *** hdl/tkc_touch_key_cmd.sv ***
/*
  host command interpreter of a touch-key matrix controller: reset, status,
  key reports, signal dumps, error and scan-line reports, setups and eeprom crc.
  assumes bytes already deframed from the serial port, key data read
  combinationally at keyIndex/setupsAddr, and an outer reset driven by resetReq.
*/
module tkc_touch_key_cmd #(
  parameter int MS_TICK      = tkc_pkg::MS_CYCLES,
  parameter int SETUPS_BYTES = tkc_pkg::SETUPS_BYTES_DEF
) (
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire logic                        rxValid,
  input  wire logic [7:0]                  rxByte,
  output logic      [7:0]                  txByte,
  output logic                             txValid,
  input  wire logic                        txReady,
  input  wire logic                        commsErrEvt,
  input  wire logic [tkc_pkg::NUM_KEYS-1:0] keyDetect,
  input  wire logic [tkc_pkg::NUM_KEYS-1:0] keyCal,
  input  wire logic [tkc_pkg::NUM_KEYS-1:0] keyEnabled,
  input  wire logic [tkc_pkg::NUM_KEYS-1:0] keyCalFail5,
  input  wire logic [tkc_pkg::NUM_KEYS-1:0] keyLowSignal,
  output logic      [5:0]                  keyIndex,
  input  wire logic [15:0]                 sigWord,
  input  wire logic [15:0]                 refWord,
  output logic      [9:0]                  setupsAddr,
  input  wire logic [7:0]                  setupsData,
  input  wire logic [15:0]                 setupsCrc,
  output logic                             eeCrcReq,
  input  wire logic                        eeCrcValid,
  input  wire logic [15:0]                 eeCrcWord,
  input  wire logic                        faultCheckFail,
  input  wire logic                        eepromCorrupt,
  input  wire logic [7:0]                  xLineFault,
  input  wire logic                        yLineFault,
  input  wire logic                        syncEnable,
  input  wire logic                        syncPulse,
  output logic                             reducedSpeed,
  output logic                             sensingHalt,
  output logic                             resetReq,
  output logic                             calAllReq
);
  import tkc_pkg::*;

  if (MS_TICK < 2 || MS_TICK > 65535) begin : g_bad_tick
    $error("MS_TICK out of range");
  end
  if (SETUPS_BYTES < 1 || SETUPS_BYTES > 1000) begin : g_bad_setups
    $error("SETUPS_BYTES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reset release and millisecond tick
  logic        rstQ1;
  logic        rstSync_n;
  logic [15:0] msCnt_r;
  logic        msTick;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {rstSync_n, rstQ1} <= 2'b00;
    end else begin
      {rstSync_n, rstQ1} <= {rstQ1, 1'b1};
    end
  end

  assign msTick = (msCnt_r == 16'(MS_TICK - 1));

  // a tick divider keeps the 100 ms windows at 7-bit counters
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      msCnt_r <= '0;
    end else begin
      msCnt_r <= msTick ? 16'h0000 : msCnt_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status views
  function automatic logic [5:0] firstKey(input logic [NUM_KEYS-1:0] v);
    logic [5:0] k;
    k = NO_KEY;
    for (int i = NUM_KEYS - 1; i >= 0; i--) begin
      if (v[i]) k = 6'(i);
    end
    return k;
  endfunction

  function automatic logic [7:0] byteOf(input logic [NUM_KEYS-1:0] v, input logic [2:0] b);
    return v[b*8 +: 8];
  endfunction

  logic                commsFlag_r;
  logic                syncErr_r;
  logic [NUM_KEYS-1:0] keyErr;
  logic [7:0]          statusByte;
  logic [7:0]          firstByte;
  logic [16:0]         diff;
  logic [7:0]          delta;

  assign keyErr     = (keyEnabled & keyLowSignal) | keyCal;
  assign statusByte = {1'b0, commsFlag_r, faultCheckFail, eepromCorrupt, syncErr_r,
                       |(keyEnabled & (keyCalFail5 | keyLowSignal)),
                       |keyCal, |keyDetect};
  assign firstByte  = {|(keyDetect & (keyDetect - 48'h1)),
                       (|statusByte[ST_COMMS:ST_CALF]) | (|keyErr),
                       firstKey(keyDetect)};
  assign diff       = {1'b0, refWord} - {1'b0, sigWord};
  // negative deltas floor at zero, large ones saturate
  assign delta      = diff[16] ? 8'h00 : (|diff[15:8] ? DELTA_MAX : diff[7:0]);

  ////////////////////////////////////////////////////////////////////////////////
  // command engine
  tkc_state_t  state_r;
  logic [7:0]  cmd_r;
  logic [7:0]  lastCmd_r;
  logic [7:0]  prevCmd_r;
  logic [9:0]  idx_r;
  logic [9:0]  nData_r;
  logic        withCrc_r;
  logic [7:0]  txByte_r;
  logic [6:0]  paceMs_r;
  logic        armed_r;
  logic [6:0]  armMs_r;
  logic [15:0] eeCrc_r;
  logic        accept;
  logic        startGo;
  logic        startCrc;
  logic [9:0]  startLen;
  logic        done;
  logic [7:0]  srcByte;
  tkc_crc_if   crcIf ();

  tkc_crc8 u_crc (
    .clock     (clock),
    .rstSync_n (rstSync_n),
    .crcIf     (crcIf.engine)
  );

  assign accept = (state_r == S_IDLE) && rxValid;
  assign done   = txReady && (idx_r == (withCrc_r ? nData_r : nData_r - 10'd1));

  // answer length per command; unknown bytes are only remembered
  always_comb begin
    startGo  = 1'b1;
    startCrc = 1'b0;
    startLen = 10'd1;
    unique case (rxByte)
      CMD_RESET:                       startGo = armed_r;
      CMD_STATUS, CMD_FIRST, CMD_FAULT_ANALYSIS_CHECK: startCrc = 1'b1;
      CMD_DETECT, CMD_ERRORS: begin
        startCrc = 1'b1;
        startLen = 10'(KEY_BYTES);
      end
      CMD_SIGNAL, CMD_REF:             startLen = 10'(2 * NUM_KEYS);
      CMD_DELTA:                       startLen = 10'(NUM_KEYS);
      CMD_DUMP:                        startLen = 10'(SETUPS_BYTES + 2);
      CMD_EECRC:                       startLen = 10'd2;
      CMD_LAST:                        startLen = 10'd1;
      default:                         startGo = 1'b0;
    endcase
  end

  // byte source follows the current index; crc byte closes answers flagged withCrc_r
  always_comb begin
    srcByte = 8'h00;
    if (withCrc_r && idx_r == nData_r) begin
      srcByte = crcIf.crc;
    end else begin
      unique case (cmd_r)
        CMD_RESET:  srcByte = RSP_RESET;
        CMD_STATUS: srcByte = statusByte;
        CMD_FIRST:  srcByte = firstByte;
        CMD_DETECT: srcByte = byteOf(keyDetect, idx_r[2:0]);
        CMD_ERRORS: srcByte = byteOf(keyErr, idx_r[2:0]);
        CMD_SIGNAL: srcByte = idx_r[0] ? sigWord[15:8] : sigWord[7:0];
        CMD_REF:    srcByte = idx_r[0] ? refWord[15:8] : refWord[7:0];
        CMD_DELTA:  srcByte = delta;
        CMD_FAULT_ANALYSIS_CHECK:   srcByte = yLineFault ? FAULT_ANALYSIS_CHECK_ALL : xLineFault;
        CMD_DUMP: begin
          if (idx_r < 10'(SETUPS_BYTES)) srcByte = setupsData;
          else srcByte = idx_r == 10'(SETUPS_BYTES) ? setupsCrc[7:0] : setupsCrc[15:8];
        end
        CMD_EECRC:  srcByte = idx_r[0] ? eeCrc_r[15:8] : eeCrc_r[7:0];
        CMD_LAST:   srcByte = ~prevCmd_r;
        default:    srcByte = 8'h00;
      endcase
    end
  end

  assign keyIndex   = (cmd_r == CMD_DELTA) ? idx_r[5:0] : idx_r[6:1];
  assign setupsAddr = idx_r;
  assign txByte     = txByte_r;
  assign txValid    = (state_r == S_SEND);
  assign crcIf.seed = accept;
  assign crcIf.feed = txValid && txReady && idx_r < nData_r;
  assign crcIf.data = accept ? rxByte : txByte_r;

  // main sequence; bytes arriving while an answer is in flight are ignored
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_r   <= S_IDLE;
      cmd_r     <= 8'h00;
      idx_r     <= '0;
      nData_r   <= 10'd1;
      withCrc_r <= 1'b0;
      txByte_r  <= 8'h00;
      paceMs_r  <= '0;
      eeCrc_r   <= 16'h0000;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          paceMs_r <= '0;
          if (accept && startGo) begin
            cmd_r     <= rxByte;
            idx_r     <= '0;
            nData_r   <= startLen;
            withCrc_r <= startCrc;
            state_r   <= (rxByte == CMD_EECRC) ? S_WAITEE : S_FETCH;
          end
        end
        S_WAITEE: begin
          if (eeCrcValid) begin
            eeCrc_r <= eeCrcWord;
            state_r <= S_FETCH;
          end else if (msTick) begin
            paceMs_r <= paceMs_r + 7'd1;
            if (paceMs_r == 7'(EECRC_MS - 1)) state_r <= S_IDLE;
          end
        end
        S_FETCH: begin
          txByte_r <= srcByte;
          paceMs_r <= '0;
          state_r  <= S_SEND;
        end
        S_SEND: begin
          if (done) begin
            state_r <= S_IDLE;
          end else if (txReady) begin
            idx_r   <= idx_r + 10'd1;
            state_r <= S_FETCH;
          end else if (msTick) begin
            paceMs_r <= paceMs_r + 7'd1;
            if (paceMs_r == 7'(TIMEOUT_MS - 1)) state_r <= S_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // last command, reset arming, comms flag
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      lastCmd_r <= 8'h00;
      prevCmd_r <= 8'h00;
    end else if (accept) begin
      lastCmd_r <= rxByte;
      prevCmd_r <= lastCmd_r;
    end
  end

  // any other byte or an expired window drops the first reset byte
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      armed_r <= 1'b0;
      armMs_r <= '0;
    end else if (accept) begin
      armed_r <= (rxByte == CMD_RESET) && !armed_r;
      armMs_r <= '0;
    end else if (armed_r && msTick) begin
      armMs_r <= armMs_r + 7'd1;
      if (armMs_r == 7'(TIMEOUT_MS - 1)) armed_r <= 1'b0;
    end
  end

  // a new fault in the clearing cycle keeps the flag set
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      commsFlag_r <= 1'b0;
    end else if (commsErrEvt) begin
      commsFlag_r <= 1'b1;
    end else if (accept && rxByte == CMD_LAST && lastCmd_r == CMD_LAST) begin
      commsFlag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // mains sync watch, sensing halt, reset and calibration requests
  logic [6:0] syncMs_r;
  logic       started_r;
  logic       halt_r;
  logic       resetReq_r;
  logic       eeReq_r;

  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      syncMs_r  <= '0;
      syncErr_r <= 1'b0;
    end else if (!syncEnable || syncPulse) begin
      syncMs_r  <= '0;
      syncErr_r <= 1'b0;
    end else if (msTick) begin
      if (syncMs_r == 7'(SYNC_MS - 1)) syncErr_r <= 1'b1;
      else syncMs_r <= syncMs_r + 7'd1;
    end
  end

  // the outer reset must follow resetReq; calibration restarts after any reset
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      started_r  <= 1'b0;
      calAllReq  <= 1'b0;
      resetReq_r <= 1'b0;
      eeReq_r    <= 1'b0;
      halt_r     <= 1'b0;
    end else begin
      started_r  <= 1'b1;
      calAllReq  <= !started_r;
      resetReq_r <= txValid && done && cmd_r == CMD_RESET;
      eeReq_r    <= accept && rxByte == CMD_EECRC;
      if (accept && rxByte == CMD_DUMP) halt_r <= 1'b1;
      else if (state_r == S_IDLE) halt_r <= 1'b0;
    end
  end

  assign reducedSpeed = syncErr_r;
  assign sensingHalt  = halt_r;
  assign resetReq     = resetReq_r;
  assign eeCrcReq     = eeReq_r;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  a_fb_before_reset: assert property (@(posedge clock) disable iff (!rstSync_n)
    resetReq |-> $past(txByte) == RSP_RESET && $past(cmd_r) == CMD_RESET)
    else $error("reset request without 0xfb answer");
  a_cal_after_reset: assert property (@(posedge clock) disable iff (!rstSync_n)
    !started_r |=> calAllReq)
    else $error("no calibration after reset");
  a_status_reserved: assert property (@(posedge clock) disable iff (!rstSync_n)
    txValid && cmd_r == CMD_STATUS && idx_r == 10'd0 |-> !txByte[7])
    else $error("status reserved bit set");
  a_first_none: assert property (@(posedge clock) disable iff (!rstSync_n)
    state_r == S_FETCH && cmd_r == CMD_FIRST && idx_r == 10'd0 && keyDetect == '0
    |=> txByte[5:0] == NO_KEY)
    else $error("idle key field not 0x3f");
  a_comms_sticky: assert property (@(posedge clock) disable iff (!rstSync_n)
    commsFlag_r && !(accept && rxByte == CMD_LAST) |=> commsFlag_r)
    else $error("comms flag cleared early");
  a_sync_error: assert property (@(posedge clock) disable iff (!rstSync_n)
    syncEnable && !syncPulse && msTick && syncMs_r == 7'(SYNC_MS - 1)
    |=> syncErr_r && reducedSpeed)
    else $error("sync error not raised");
  a_halt_dump: assert property (@(posedge clock) disable iff (!rstSync_n)
    state_r != S_IDLE && cmd_r == CMD_DUMP |-> sensingHalt)
    else $error("sensing not halted in dump");
  a_pace_abort: assert property (@(posedge clock) disable iff (!rstSync_n)
    txValid && !txReady && msTick && paceMs_r == 7'(TIMEOUT_MS - 1) |=> state_r == S_IDLE)
    else $error("slow host did not abort");
  a_fast_start: assert property (@(posedge clock) disable iff (!rstSync_n)
    accept && rxByte == CMD_STATUS |-> ##2 txValid && txByte == statusByte)
    else $error("status answer late");

endmodule

// *** testbench/tkc_host_model.sv ***
/*
  host side of the byte port: sends command bytes and takes answer bytes.
  assumes the block samples its byte port on the rising clock edge.
*/
module tkc_host_model (
  input  wire logic       clock,
  output logic            rxValid,
  output logic [7:0]      rxByte,
  input  wire logic [7:0] txByte,
  input  wire logic       txValid,
  output logic            txReady
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    rxValid = 1'b0;
    rxByte  = 8'h5a;
    txReady = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one byte, one cycle wide; data inverted after so a stale byte never looks valid
  task automatic send(input logic [7:0] b);
    @(negedge clock);
    rxValid = 1'b1;
    rxByte  = b;
    @(negedge clock);
    rxValid = 1'b0;
    rxByte  = ~b;
  endtask

  // bounded wait for an answer byte, ready held across exactly one rising edge
  task automatic take(input int lim, output logic [7:0] b, output logic ok);
    ok = 1'b0;
    b  = 8'h00;
    for (int i = 0; i < lim && !ok; i++) begin
      @(negedge clock);
      if (txValid === 1'b1) ok = 1'b1;
    end
    if (ok) begin
      b       = txByte;
      txReady = 1'b1;
      @(negedge clock);
      txReady = 1'b0;
    end
  endtask
endmodule

// *** testbench/tkc_touch_key_cmd_test.sv ***
/*
  self-checking bench for the touch-key command block, ms tick shortened to 10.
  assumes the host model above and key data served from keyIndex combinationally.
*/
module tkc_touch_key_cmd_test;
  import tkc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock, rst_n, commsErrEvt, faultCheckFail, eepromCorrupt, yLineFault;
  logic syncEnable, syncPulse, eeCrcValid, rxValid, txValid, txReady, eeCrcReq;
  logic reducedSpeed, sensingHalt, resetReq, calAllReq, commsExp, syncExp, ok;
  logic [47:0] keyDetect, keyCal, keyEnabled, keyCalFail5, keyLowSignal;
  logic [7:0]  xLineFault, rxByte, txByte, crc, b;
  logic [15:0] eeCrcWord, sigWord, refWord, setupsCrc, w;
  logic [5:0]  keyIndex;
  logic [9:0]  setupsAddr;
  int          fails, checksDone, calCnt;

  function automatic logic [15:0] refOf(input logic [5:0] k);
    return {10'h040, k};
  endfunction
  // three delta cases chosen by key index mod 3: clamped high, negative, plain
  function automatic logic [15:0] sigOf(input logic [5:0] k);
    return (k % 3 == 0) ? refOf(k) - 16'h012c : (k % 3 == 1) ? refOf(k) + 16'h0001
           : refOf(k) - {10'h000, k};
  endfunction
  function automatic logic [7:0] crcUpd(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    repeat (8) r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    return r;
  endfunction
  function automatic logic [7:0] stat();
    return {1'b0, commsExp, faultCheckFail, eepromCorrupt, syncExp,
            |(keyEnabled & (keyCalFail5 | keyLowSignal)), |keyCal, |keyDetect};
  endfunction

  logic [7:0] setupsData;
  assign sigWord    = sigOf(keyIndex);
  assign refWord    = refOf(keyIndex);
  assign setupsData = 8'ha0 ^ setupsAddr[7:0];

  tkc_touch_key_cmd #(.MS_TICK(10), .SETUPS_BYTES(4)) dut (.clock(clock), .rst_n(rst_n),
    .rxValid(rxValid), .rxByte(rxByte), .txByte(txByte), .txValid(txValid),
    .txReady(txReady), .commsErrEvt(commsErrEvt), .keyDetect(keyDetect), .keyCal(keyCal),
    .keyEnabled(keyEnabled), .keyCalFail5(keyCalFail5), .keyLowSignal(keyLowSignal),
    .keyIndex(keyIndex), .sigWord(sigWord), .refWord(refWord), .setupsAddr(setupsAddr),
    .setupsData(setupsData), .setupsCrc(setupsCrc), .eeCrcReq(eeCrcReq),
    .eeCrcValid(eeCrcValid), .eeCrcWord(eeCrcWord), .faultCheckFail(faultCheckFail),
    .eepromCorrupt(eepromCorrupt), .xLineFault(xLineFault), .yLineFault(yLineFault),
    .syncEnable(syncEnable), .syncPulse(syncPulse), .reducedSpeed(reducedSpeed),
    .sensingHalt(sensingHalt), .resetReq(resetReq), .calAllReq(calAllReq));
  tkc_host_model host (.clock(clock), .rxValid(rxValid), .rxByte(rxByte),
    .txByte(txByte), .txValid(txValid), .txReady(txReady));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // calibrate requests seen since time zero
  always @(posedge clock) if (calAllReq === 1'b1) calCnt++;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    check8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic ask(input logic [7:0] c);
    host.send(c);
    crc = crcUpd(8'h00, c);
  endtask
  // a missing answer ends the run, it cannot be recovered from
  task automatic expect_byte(input logic [7:0] e);
    host.take(12, b, ok);
    if (!ok) begin
      fails++;
      tally_and_finish();
    end
    check8(b, e);
    crc = crcUpd(crc, e);
  endtask
  task automatic expect_none(input int lim);
    host.take(lim, b, ok);
    check1(ok, 1'b0);
  endtask
  task automatic status_check;
    ask(CMD_STATUS);
    expect_byte(stat());
    expect_byte(crc);
  endtask
  task automatic wait_pulse(input bit ee);
    for (int i = 0; i < 30 && ((ee ? eeCrcReq : resetReq) !== 1'b1); i++) @(negedge clock);
    if ((ee ? eeCrcReq : resetReq) !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    repeat (8) @(negedge clock);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {commsErrEvt, faultCheckFail, eepromCorrupt, yLineFault, syncEnable} = 5'h00;
    {syncPulse, eeCrcValid, commsExp, syncExp} = 4'h0;
    {keyDetect, keyCal, keyCalFail5, keyLowSignal} = '0;
    keyEnabled = 48'hffff_ffff_fbff;
    {xLineFault, eeCrcWord, setupsCrc} = {8'h00, 16'hbeef, 16'hc35a};
    {fails, checksDone, calCnt} = '0;
    do_reset();
    check8(calCnt[7:0], 8'h01);
    keyDetect[5] = 1'b1;
    keyDetect[40] = 1'b1;
    keyLowSignal[10:9] = 2'b11;
    keyCal[2] = 1'b1;
    faultCheckFail = 1'b1;
    status_check();
    ask(CMD_FIRST);
    expect_byte(8'hc5);
    expect_byte(crc);
    ask(CMD_DETECT);
    for (int i = 0; i < 6; i++) expect_byte(keyDetect[i*8 +: 8]);
    expect_byte(crc);
    ask(CMD_ERRORS);
    for (int i = 0; i < 6; i++) expect_byte(i == 0 ? 8'h04 : i == 1 ? 8'h02 : 8'h00);
    expect_byte(crc);
    keyDetect = '0;
    keyCal[2] = 1'b0;
    ask(CMD_ERRORS);
    expect_byte(8'h00);
    expect_byte(8'h02);
    repeat (4) expect_byte(8'h00);
    expect_byte(crc);
    ask(CMD_FIRST);
    expect_byte({2'b01, NO_KEY});
    expect_byte(crc);
    $display("test status and key reports done");
    for (int c = 8; c < 11; c++) begin
      ask(c[7:0]);
      for (int k = 0; k < 48; k++) begin
        w = (c == 8) ? sigOf(k[5:0]) : refOf(k[5:0]);
        if (c == 10) expect_byte(k % 3 == 0 ? 8'hff : k % 3 == 1 ? 8'h00 : k[7:0]);
        else expect_byte(w[7:0]);
        if (c != 10) expect_byte(w[15:8]);
      end
      expect_none(20);
    end
    $display("test dumps done");
    xLineFault = 8'h12;
    ask(CMD_FAULT_ANALYSIS_CHECK);
    expect_byte(8'h12);
    expect_byte(crc);
    yLineFault = 1'b1;
    ask(CMD_FAULT_ANALYSIS_CHECK);
    expect_byte(FAULT_ANALYSIS_CHECK_ALL);
    expect_byte(crc);
    ask(CMD_DUMP);
    for (int i = 0; i < 4; i++) expect_byte(8'ha0 ^ i[7:0]);
    check1(sensingHalt, 1'b1);
    expect_byte(setupsCrc[7:0]);
    expect_byte(setupsCrc[15:8]);
    repeat (4) @(negedge clock);
    check1(sensingHalt, 1'b0);
    ask(CMD_DUMP);
    expect_byte(8'ha0);
    repeat (1100) @(negedge clock);
    check1(txValid, 1'b0);
    ask(CMD_EECRC);
    wait_pulse(1'b1);
    @(negedge clock);
    eeCrcValid = 1'b1;
    @(negedge clock);
    eeCrcValid = 1'b0;
    expect_byte(8'hef);
    expect_byte(8'hbe);
    expect_none(20);
    $display("test scan lines, setups and eeprom done");
    @(negedge clock);
    commsErrEvt = 1'b1;
    @(negedge clock);
    commsErrEvt = 1'b0;
    commsExp = 1'b1;
    status_check();
    ask(CMD_LAST);
    expect_byte(~CMD_STATUS);
    ask(CMD_LAST);
    expect_byte(8'hf0);
    commsExp = 1'b0;
    status_check();
    syncEnable = 1'b1;
    repeat (1100) @(negedge clock);
    check1(reducedSpeed, 1'b1);
    syncExp = 1'b1;
    status_check();
    syncPulse = 1'b1;
    @(negedge clock);
    syncPulse = 1'b0;
    syncExp = 1'b0;
    status_check();
    $display("test comms and sync flags done");
    // corrupt eeprom reported: the host answers it with a forced reset
    eepromCorrupt = 1'b1;
    ask(CMD_RESET);
    expect_none(12);
    status_check();
    ask(CMD_RESET);
    ask(CMD_RESET);
    expect_byte(RSP_RESET);
    wait_pulse(1'b0);
    do_reset();
    check8(calCnt[7:0], 8'h02);
    $display("test forced reset done");
    tally_and_finish();
  end
endmodule
